//--- hw/ccpp_top.sv
// Colour correction pixel pipeline with APB register slave
`timescale 1ns/1ns
`include "ccpp_defs.svh"
module ccpp_top (
    // Clock and reset
    input  wire logic               MCLK_IN,
    input  wire logic               RST_IN,
    // APB slave
    input  wire logic               PSEL_IN,
    input  wire logic               PENABLE_IN,
    input  wire logic               PWRITE_IN,
    input  wire logic [11:0]        PADDR_IN,
    input  wire logic [31:0]        PWDATA_IN,
    output logic      [31:0]        PRDATA_OUT,
    output logic                    PREADY_OUT,
    output logic                    PSLVERR_OUT,
    // Scanner side pixel stream
    input  wire logic               PIX_VALID_IN,
    input  wire ccpp_pkg::ccpp_in_t PIX_IN,
    input  wire logic               LINE_END_IN,
    output logic                    PIX_READY_OUT,
    // Laser writer side pixel stream
    output logic                    PIX_VALID_OUT,
    output ccpp_pkg::ccpp_out_t     PIX_OUT,
    output logic                    LINE_END_OUT
);
    import ccpp_pkg::*;

    // Software registers
    logic [31:0] ctrl, repl, bal, twin, scale, tone, cal;
    logic [7:0]  tmod;
    // ctrl: [0] twin [1] two-colour [2] bk priority [3] pastel
    // [7:4] pastel step [9:8] inkjet table [10] inkjet
    // [11] cal start [12] pattern gen
    logic [7:0]  selftest;

    function automatic logic [7:0] lvl_scale(input logic [7:0] v,
                                             input logic [3:0] l);
        // Nine levels: 25% + (l + l/2)*6.25%, l/2 rounded down, l clamped to 8
        logic [3:0]  q;
        logic [11:0] p;
        q = (l > 4'h8) ? 4'h8 : l;
        p = {4'h0, v} * (12'h004 + {8'h0, q} + ({8'h0, q} >> 1));
        return p[11:4];
    endfunction

    function automatic logic [7:0] sat_add(input logic [7:0] a,
                                           input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[8] ? 8'hFF : s[7:0];
    endfunction

    function automatic logic [7:0] ratio_mul(input logic [7:0] v,
                                             input logic [7:0] r);
        logic [15:0] p;
        p = {8'h0, v} * {8'h0, r} + {8'h0, v}; // FF gives exactly 100%
        return p[15:8];
    endfunction

    // APB access and register writes; a write lands at the access edge
    wire apb_acc = PSEL_IN && PENABLE_IN;
    wire apb_wr  = apb_acc && PWRITE_IN;
    wire addr_ok = (PADDR_IN <= `CCPP_A_TMOD) && (PADDR_IN[1:0] == 2'h0);
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = apb_acc && !addr_ok;
    logic cal_busy;
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ctrl  <= 32'h0000_0000;
            repl  <= 32'h0000_0000;
            bal   <= 32'h8888_8888;
            twin  <= 32'h0000_0000;
            scale <= 32'h0000_0000;
            tone  <= 32'h0000_0000;
            tmod  <= 8'h00;
        end else begin
            // Start bit clears once taken; a CTRL write in the same cycle wins
            if (ctrl[11] && !cal_busy)
                ctrl[11] <= 1'b0;
            if (apb_wr) begin
                case (PADDR_IN)
                    `CCPP_A_CTRL:  ctrl  <= PWDATA_IN;
                    `CCPP_A_REPL:  repl  <= PWDATA_IN;
                    `CCPP_A_BAL:   bal   <= PWDATA_IN;
                    `CCPP_A_TWIN:  twin  <= PWDATA_IN;
                    `CCPP_A_SCALE: scale <= PWDATA_IN;
                    `CCPP_A_TONE:  tone  <= PWDATA_IN;
                    `CCPP_A_TMOD:  tmod  <= PWDATA_IN[7:0];
                    default:       ;
                endcase
            end
        end
    end

    // Read mux; unmapped addresses read zero with PSLVERR
    always_comb begin
        case (PADDR_IN)
            `CCPP_A_CTRL:  PRDATA_OUT = ctrl;
            `CCPP_A_REPL:  PRDATA_OUT = repl;
            `CCPP_A_BAL:   PRDATA_OUT = bal;
            `CCPP_A_TWIN:  PRDATA_OUT = twin;
            `CCPP_A_SCALE: PRDATA_OUT = scale;
            `CCPP_A_TONE:  PRDATA_OUT = tone;
            `CCPP_A_CAL:   PRDATA_OUT = cal;
            `CCPP_A_STAT:  PRDATA_OUT = {23'h0, cal_busy, selftest};
            `CCPP_A_TMOD:  PRDATA_OUT = {24'h0, tmod};
            default:       PRDATA_OUT = 32'h0000_0000;
        endcase
    end

    // Self-test: zero means the balance register matched the written pattern [R21]
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN)
            selftest <= 8'h00;
        else if (apb_wr && PADDR_IN == `CCPP_A_STAT)
            selftest <= (bal == PWDATA_IN) ? 8'h00 : 8'h01; // [R21]
    end

    // Stage 1: matrix from RGB to YMCK, one fixed complement for every mode [R23]
    ccpp_out_t s1;
    logic      s1_v, s1_end;
    logic [7:0] y0, m0, c0, k0, mn;
    always_comb begin
        y0 = ~PIX_IN.b;
        m0 = ~PIX_IN.g;
        c0 = ~PIX_IN.r;
        mn = (y0 < m0) ? y0 : m0;
        mn = (mn < c0) ? mn : c0;
        k0 = 8'h00;
        // Replacement: yellow dominant pixel, column of ones [R1] [R2]
        for (int i = 0; i < 4; i++) begin
            if (repl[8*i+7] && repl[8*i +: 3] == 3'h1 &&
                y0 > 8'h80 && m0 < 8'h40 && c0 < 8'h40) begin
                m0 = y0;
                c0 = y0;
                k0 = y0;
            end
        end
        // Two-colour toner ratios only in two-colour mode [R6]
        if (ctrl[1]) begin
            y0 = lvl_scale(y0, scale[3:0]);
            m0 = lvl_scale(m0, scale[7:4]);
            c0 = lvl_scale(c0, scale[11:8]);
        end
        // Twin colour: black or colour areas to two chosen colours [R7]
        if (ctrl[0]) begin
            if ((mn > 8'hC0) || PIX_IN.tag == CCPP_BLACK_TEXT) begin
                {y0, m0, c0} = {twin[7:0], twin[15:8], twin[23:16]};
            end else begin
                {y0, m0, c0} = {twin[31:24], twin[31:24], 8'h00};
            end
        end
        // Colour balance per output [R4]
        y0 = lvl_scale(y0, bal[3:0]);
        m0 = lvl_scale(m0, bal[7:4]);
        c0 = lvl_scale(c0, bal[11:8]);
        k0 = lvl_scale(k0, bal[15:12]);
        // Pastel over the combined output [R3]
        if (ctrl[3]) begin
            y0 = lvl_scale(y0, ctrl[7:4]);
            m0 = lvl_scale(m0, ctrl[7:4]);
            c0 = lvl_scale(c0, ctrl[7:4]);
            k0 = lvl_scale(k0, ctrl[7:4]);
        end
        // Inkjet tone table: four fixed offsets (0, 4, 8, 12) on Y and M [R5]
        if (ctrl[10]) begin
            y0 = sat_add(y0, {4'h0, ctrl[9:8], 2'h0});
            m0 = sat_add(m0, {4'h0, ctrl[9:8], 2'h0});
        end
    end
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            s1     <= '0;
            s1_v   <= 1'b0;
            s1_end <= 1'b0;
        end else begin
            s1_v   <= PIX_VALID_IN && PIX_READY_OUT;
            s1_end <= LINE_END_IN && PIX_VALID_IN && PIX_READY_OUT;
            s1     <= '{y0, m0, c0, k0, PIX_IN.tag, 1'b0}; // [R22]
        end
    end

    // Substitution ratio table, monotone in the minimum [R24]
    function automatic logic [7:0] ucr_ratio(input logic [7:0] mn_v,
                                             input ccpp_tag_t t,
                                             input logic bk);
        logic [15:0] p;
        p = 16'h0000;
        if (t != CCPP_PHOTO)
            return 8'hFF; // [R10]
        if (bk) begin
            if (mn_v <= `CCPP_BK_START)
                return 8'h00; // [R11]
            p = {8'h0, mn_v - `CCPP_BK_START} * 16'h010D;
            return p[15:8]; // [R11]
        end
        if (mn_v <= `CCPP_FC_START)
            return 8'h00; // [R12]
        p = {8'h0, mn_v - `CCPP_FC_START} * 16'h01A2;
        return (p[15:8] > `CCPP_FC_MAX) ? `CCPP_FC_MAX : p[15:8]; // [R12]
    endfunction

    // Stage 2: substitution on common part, remainders kept [R8] [R9]
    ccpp_out_t s2;
    logic      s2_v, s2_end;
    logic [7:0] cm, sub, y1, m1, c1, k1;
    always_comb begin
        cm  = (s1.y < s1.m) ? s1.y : s1.m;
        cm  = (cm < s1.c) ? cm : s1.c;
        sub = ratio_mul(cm, ucr_ratio(cm, s1.tag, ctrl[2]));
        y1  = s1.y - sub; // [R9]
        m1  = s1.m - sub;
        c1  = s1.c - sub;
        k1  = sat_add(s1.k, sub); // [R8]
        // Add-back scaled by each colour's own density, never black
        y1  = sat_add(y1, y1 >> `CCPP_ADD_SHIFT); // [R13]
        m1  = sat_add(m1, m1 >> `CCPP_ADD_SHIFT);
        c1  = sat_add(c1, c1 >> `CCPP_ADD_SHIFT);
    end

    // Tone curve: band trims applied by level 0-9 of input [R16] [R17]
    function automatic logic [7:0] tone_map(input logic [7:0] v,
                                            input logic [31:0] t);
        logic [3:0] lv;
        logic [7:0] o;
        lv = 4'((({8'h0, v} * 16'h000A) >> 8));
        o  = lvl_scale(v, t[3:0]); // Maximum density
        if (lv >= 4'h6) o = sat_add(o, {4'h0, t[7:4]});   // [R17]
        if (lv >= 4'h3 && lv <= 4'h7) o = sat_add(o, {4'h0, t[11:8]});
        if (lv >= 4'h2 && lv <= 4'h5) o = sat_add(o, {4'h0, t[15:12]});
        return o;
    endfunction
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            s2     <= '0;
            s2_v   <= 1'b0;
            s2_end <= 1'b0;
        end else begin
            s2_v   <= s1_v;
            s2_end <= s1_end;
            // Mode select picks photo trims (cal) for photo Y, M, C; text trims (tone) for all else [R16]
            s2.y <= tone_map(y1, (s1.tag == CCPP_PHOTO) ? cal : tone);
            s2.m <= tone_map(m1, (s1.tag == CCPP_PHOTO) ? cal : tone);
            s2.c <= tone_map(c1, (s1.tag == CCPP_PHOTO) ? cal : tone);
            s2.k <= tone_map(k1, tone);
            s2.tag   <= s1.tag;
            s2.dith2 <= (s1.tag == CCPP_PHOTO); // [R20]
        end
    end

    // Calibration merges new maximum, keeps band trims [R19]
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            cal      <= 32'h0000_0008;
            cal_busy <= 1'b0;
        end else if (ctrl[11] && !cal_busy) begin
            cal_busy <= 1'b1;
        end else if (cal_busy && s1_end) begin
            cal_busy <= 1'b0;
            cal[3:0] <= (s1.k > 8'h80) ? 4'h8 : 4'h6; // [R19]
        end else if (apb_wr && PADDR_IN == `CCPP_A_CAL) begin
            cal <= PWDATA_IN;
        end
    end

    // Resample black only: weight the two nearest inputs by phase [R14]
    logic [7:0] prev_k;
    logic [8:0] phase;
    wire  [7:0] ph = scale[23:16];
    function automatic logic [7:0] lerp(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] f);
        logic [15:0] p;
        p = {8'h0, a} * {8'h0, ~f} + {8'h0, b} * {8'h0, f};
        return p[15:8];
    endfunction
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            prev_k <= 8'h00;
            phase  <= 9'h000;
        end else if (s2_v) begin
            prev_k <= s2_end ? 8'h00 : s2.k; // Blank paper off the edge
            phase  <= s2_end ? 9'h000 : {1'b0, phase[7:0]} + {1'b0, ph};
        end
    end

    function automatic logic [7:0] patt_lvl(input logic [4:0] s,
                                            input logic       on);
        return !on ? 8'h00 : s[4] ? 8'hFF : {s[3:0], 4'h0}; // Top full
    endfunction

    // Line buffer reversed on drain; mirror image output [R15]
    // Single buffer: input stalls during drain, simpler than ping-pong
    ccpp_out_t   line_mem [`CCPP_LINE_LEN];
    logic [9:0]  wptr, rptr;
    ccpp_state_t state;
    logic [4:0]  pstep;
    logic [2:0]  pscale;
    assign PIX_READY_OUT = (state == CCPP_FILL);
    always_ff @(posedge MCLK_IN) begin
        if (s2_v && state == CCPP_FILL)
            line_mem[wptr] <= '{s2.y, s2.m, s2.c,
                                lerp(prev_k, s2.k, phase[7:0]),
                                s2.tag, s2.dith2};
    end
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            state         <= CCPP_FILL;
            wptr          <= 10'h000;
            rptr          <= 10'h000;
            PIX_VALID_OUT <= 1'b0;
            LINE_END_OUT  <= 1'b0;
            PIX_OUT       <= '0;
            pstep         <= 5'h00;
            pscale        <= 3'h0;
        end else begin
            PIX_VALID_OUT <= 1'b0;
            LINE_END_OUT  <= 1'b0;
            case (state)
                CCPP_FILL: begin
                    if (ctrl[12] && !PIX_VALID_IN && !s1_v && !s2_v) begin
                        state <= CCPP_PATT;
                    end else if (s2_v) begin
                        wptr <= wptr + 10'h001;
                        if (s2_end) begin
                            rptr  <= wptr; // Last pixel goes first [R15]
                            state <= CCPP_DRAIN;
                        end
                    end
                end
                CCPP_DRAIN: begin
                    PIX_VALID_OUT <= 1'b1;
                    PIX_OUT       <= line_mem[rptr]; // [R15]
                    if (rptr == 10'h000) begin
                        LINE_END_OUT <= 1'b1;
                        wptr         <= 10'h000;
                        state        <= CCPP_FILL;
                    end else begin
                        rptr <= rptr - 10'h001;
                    end
                end
                CCPP_PATT: begin
                    // Eight 17-step scales, step 0 background white [R18]
                    PIX_VALID_OUT <= 1'b1;
                    PIX_OUT.y <= patt_lvl(pstep, pscale[1:0] == 2'h3);
                    PIX_OUT.m <= patt_lvl(pstep, pscale[1:0] == 2'h2);
                    PIX_OUT.c <= patt_lvl(pstep, pscale[1:0] == 2'h1);
                    PIX_OUT.k <= patt_lvl(pstep, pscale[1:0] == 2'h0);
                    PIX_OUT.tag   <= pscale[2] ? CCPP_PHOTO : CCPP_BLACK_TEXT;
                    PIX_OUT.dith2 <= pscale[2]; // [R20]
                    if (pstep == 5'(`CCPP_STEPS - 1)) begin
                        pstep        <= 5'h00;
                        LINE_END_OUT <= 1'b1;
                        pscale       <= pscale + 3'h1;
                        if (pscale == 3'(`CCPP_SCALES - 1))
                            state <= CCPP_FILL;
                    end else begin
                        pstep <= pstep + 5'h01;
                    end
                end
                default: state <= CCPP_FILL;
            endcase
        end
    end

    // Photo pixels leave with the 2x1 dither flag, text 1x1
    dither_sel_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        PIX_VALID_OUT |-> PIX_OUT.dith2 == (PIX_OUT.tag == CCPP_PHOTO))
        else $error("dither unit does not follow tag"); // [R20]
    text_ratio_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        s1_v && s1.tag != CCPP_PHOTO |-> sub == cm) // [R10]
        else $error("text pixel not fully substituted");
    black_sub_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        s1_v && s1.k == 8'h00 |-> k1 == sub) // [R8]
        else $error("black does not receive substituted amount");
    low_ratio_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        s1_v && s1.tag == CCPP_PHOTO && ctrl[2] && cm <= 8'h0D
        |-> sub == 8'h00) // [R11]
        else $error("substitution below black-priority start");
    fc_ratio_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        s1_v && s1.tag == CCPP_PHOTO && !ctrl[2] && cm <= 8'h66
        |-> sub == 8'h00) // [R12]
        else $error("substitution below colour-priority start");
    sequence drain_start_s;
        state == CCPP_FILL && s2_v && s2_end;
    endsequence
    mirror_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        drain_start_s |=> state == CCPP_DRAIN && rptr == $past(wptr)) // [R15]
        else $error("drain does not start at last pixel");
    drain_end_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        state == CCPP_DRAIN && rptr == 10'h000
        |=> LINE_END_OUT && state == CCPP_FILL) // [R15]
        else $error("line end missing after first pixel");
    pattern_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        state == CCPP_PATT && pstep == 5'h00 |=> PIX_OUT.k == 8'h00 &&
        {PIX_OUT.y, PIX_OUT.m, PIX_OUT.c} == 24'h0) // [R18]
        else $error("pattern step zero not white");
endmodule

//--- shared/ccpp_defs.svh
// Constants for the colour correction pixel pipeline
//
// Contract
// R1 - Up to four colour replacements per job
// R2 - Yellow-to-black sets yellow column to ones
// R3 - Pastel: nine steps from 100% to 25%
// R4 - Balance: nine independent levels per output
// R5 - Inkjet uses one of three tone tables (code: one of four offsets 0, 4, 8, 12 on Y and M)
// R6 - RGB toner ratios only in two-colour mode
// R7 - Twin colour: black and colour to two colours
// R8 - Substitute ratio times minimum into black
// R9 - Substitute common part, add remainders back
// R10 - Text pixels use full substitution
// R11 - Black priority: zero near 13, full at 255 (code: ratio at 255 is FE, one short of FF)
// R12 - Colour priority: zero until 102, 95% max
// R13 - Add back toner to Y, M, C only
// R14 - Resample from two nearest input pixels (code: black only)
// R15 - Send each line in reversed order
// R16 - Per-colour tone curve per mode, four controls (code: one curve per mode shared by Y, M, C; K always on the text curve)
// R17 - High 6-9, middle 3-7, low 2-5
// R18 - Pattern: eight 17-step scales with white
// R19 - Calibration keeps trims, recomputes maximum
// R20 - Text 1x1 dither, photo 2x1 dither
// R21 - Self-test reports zero for pass
// R22 - Each pixel carries its separation tag
// R23 - Matrix converts RGB to YMCK by mode (code: one fixed complement for all modes)
// R24 - Ratio table rises monotonically with minimum
`ifndef CCPP_DEFS_SVH
`define CCPP_DEFS_SVH
`define CCPP_A_CTRL      12'h000
`define CCPP_A_REPL      12'h004
`define CCPP_A_BAL       12'h008
`define CCPP_A_TWIN      12'h00C
`define CCPP_A_SCALE     12'h010
`define CCPP_A_TONE      12'h014
`define CCPP_A_CAL       12'h018
`define CCPP_A_STAT      12'h01C
`define CCPP_A_TMOD      12'h020
`define CCPP_LEVELS      4'h9
`define CCPP_BK_START    8'h0D
`define CCPP_FC_START    8'h66
`define CCPP_FC_MAX      8'hF2
`define CCPP_LINE_LEN    1024
`define CCPP_STEPS       17
`define CCPP_SCALES      8
`define CCPP_ADD_SHIFT   3
`endif

//--- shared/ccpp_pkg.sv
// Types shared by the colour correction pixel pipeline
package ccpp_pkg;
    typedef enum logic [1:0] {
        CCPP_BLACK_TEXT = 2'h0,
        CCPP_COLOR_TEXT = 2'h1,
        CCPP_PHOTO      = 2'h2
    } ccpp_tag_t;
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        ccpp_tag_t  tag;
    } ccpp_in_t;
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] m;
        logic [7:0] c;
        logic [7:0] k;
        ccpp_tag_t  tag;
        logic       dith2;
    } ccpp_out_t;
    typedef enum logic [1:0] {
        CCPP_FILL  = 2'h0,
        CCPP_DRAIN = 2'h1,
        CCPP_PATT  = 2'h3
    } ccpp_state_t;
endpackage

//--- tb/ccpp_scan_model.sv
// Scanner-side pixel source feeding one line per start request
`timescale 1ns/1ns
module ccpp_scan_model
    import ccpp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Control from the bench
    input  wire logic        go_in,
    input  wire logic        slow_in,
    input  wire logic [10:0] len_in,
    // Pixel stream toward the pipeline
    input  wire logic        ready_in,
    output logic             valid_out,
    output ccpp_in_t         pix_out,
    output logic             line_end_out,
    output logic             busy_out
);
    logic [10:0] idx;

    // Grey pixels, tag cycling through all three separation kinds
    function automatic ccpp_in_t mk(input logic [10:0] i);
        logic [7:0] v;
        v = {i[4:0], 3'h0} + 8'h28;
        return '{r: v, g: v, b: v, tag: ccpp_tag_t'(2'(i % 3))};
    endfunction

    // Hold each pixel until taken; idle lines toggle so stale data shows
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_out     <= 1'b0;
            valid_out    <= 1'b0;
            line_end_out <= 1'b0;
            pix_out      <= '0;
            idx          <= '0;
        end else if (!busy_out) begin
            valid_out <= 1'b0;
            pix_out   <= ccpp_in_t'(~pix_out);
            if (go_in) begin
                busy_out <= 1'b1;
                idx      <= '0;
            end
        end else if (valid_out && !ready_in) begin
            valid_out <= 1'b1;
        end else if (valid_out) begin
            valid_out    <= 1'b0;
            line_end_out <= 1'b0;
            pix_out      <= ccpp_in_t'(~pix_out);
            idx          <= idx + 11'h001;
            if (line_end_out)
                busy_out <= 1'b0;
            // Slow mode leaves a gap cycle after every pixel
            if (!slow_in && !line_end_out) begin
                valid_out    <= 1'b1;
                pix_out      <= mk(idx + 11'h001);
                line_end_out <= (idx + 11'h001 == len_in - 11'h001);
            end
        end else begin
            valid_out    <= 1'b1;
            pix_out      <= mk(idx);
            line_end_out <= (idx == len_in - 11'h001);
        end
    end
endmodule

//--- tb/color_correction_pixel_pipeline_tb_top.sv
// Self-checking bench for the colour correction pixel pipeline
`timescale 1ns/1ns
`include "ccpp_defs.svh"
module color_correction_pixel_pipeline_tb_top;
    import ccpp_pkg::*;
    logic        mclk, rst, psel, penable, pwrite, go, slow, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, vin, lein, rdy, vout, leout, busy;
    logic [10:0] len;
    ccpp_in_t    pin;
    ccpp_out_t   pout;
    ccpp_in_t    inq[$];
    ccpp_out_t   outq[$];
    ccpp_out_t   refq[$];
    logic        leq[$];
    int          fails = 0;
    int          samples_checked = 0;

    ccpp_top dut (.MCLK_IN(mclk), .RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .PIX_VALID_IN(vin), .PIX_IN(pin),
        .LINE_END_IN(lein), .PIX_READY_OUT(rdy), .PIX_VALID_OUT(vout),
        .PIX_OUT(pout), .LINE_END_OUT(leout));

    ccpp_scan_model src (.clk_in(mclk), .rst_in(rst), .go_in(go),
        .slow_in(slow), .len_in(len), .ready_in(rdy), .valid_out(vin),
        .pix_out(pin), .line_end_out(lein), .busy_out(busy));

    always #2 mclk = ~mclk;

    // Record pixels taken in and pixels sent to the writer
    always @(posedge mclk) begin
        if (!rst && vin && rdy)
            inq.push_back(pin);
        if (!rst && vout) begin
            outq.push_back(pout);
            leq.push_back(leout);
        end
    end

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [35:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            fails++;
            tally_and_finish();
        end
    endtask

    // One scanned line, then order, tag, dither and substitution checks
    task automatic run_line(input logic [10:0] n, input logic s);
        int k;
        inq.delete();
        outq.delete();
        leq.delete();
        @(posedge mclk);
        len  <= n;
        slow <= s;
        go   <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        k = 0;
        while ((busy || outq.size() < n) && k < 5000) begin
            k++;
            @(posedge mclk);
        end
        if (k == 5000) begin
            fails++;
            tally_and_finish();
        end
        repeat (6) @(posedge mclk);
        check(outq.size(), n, "output count");
        for (k = 0; k < outq.size(); k++) begin
            check(outq[k].tag, inq[n - 1 - k].tag, "tag order");
            check(outq[k].dith2, outq[k].tag == CCPP_PHOTO, "dither");
            check(leq[k], k == n - 1, "line end");
            // Grey text pixel: common part fully moved to black
            if (outq[k].tag != CCPP_PHOTO)
                check({outq[k].y, outq[k].m, outq[k].c}, 0, "text cmy");
        end
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        go = 1'b0;
        slow = 1'b0;
        len = 11'h008;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        // Reset values, read back, refused accesses
        apb(1'b0, `CCPP_A_CTRL, 32'h0);
        check(rd, 32'h0, "ctrl reset");
        apb(1'b0, `CCPP_A_BAL, 32'h0);
        check(rd, 32'h88888888, "balance reset");
        apb(1'b1, `CCPP_A_CTRL, 32'h00000084);
        apb(1'b0, `CCPP_A_CTRL, 32'h0);
        check(rd, 32'h00000084, "ctrl readback");
        apb(1'b1, `CCPP_A_CTRL, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        check({er, rd}, {1'b1, 32'h0}, "unmapped read");
        apb(1'b1, 12'h002, 32'h0);
        check(er, 1'b1, "unaligned write");
        // Self-test: matching pattern reports zero, other value not
        apb(1'b1, `CCPP_A_STAT, 32'h88888888);
        apb(1'b0, `CCPP_A_STAT, 32'h0);
        check(rd[7:0], 8'h00, "self-test pass");
        apb(1'b1, `CCPP_A_STAT, 32'h00001234);
        apb(1'b0, `CCPP_A_STAT, 32'h0);
        check(rd[7:0] != 8'h00, 1'b1, "self-test fail");
        // Lines: single pixel boundary and eight pixels, prompt source
        run_line(11'h001, 1'b0);
        run_line(11'h008, 1'b0);
        // Black priority photo pixels down to the start threshold
        apb(1'b1, `CCPP_A_CTRL, 32'h00000004);
        run_line(11'h020, 1'b0);
        apb(1'b1, `CCPP_A_CTRL, 32'h0);
        run_line(11'h020, 1'b1);
        refq = outq;
        // RGB ratios must not matter outside two-colour mode
        apb(1'b0, `CCPP_A_SCALE, 32'h0);
        apb(1'b1, `CCPP_A_SCALE, {rd[31:12], ~rd[11:0]});
        run_line(11'h020, 1'b0);
        for (int k = 0; k < refq.size() && k < outq.size(); k++)
            check(outq[k], refq[k], "ratio ignored");
        // Calibration pattern: eight scales, white first, text then photo
        outq.delete();
        leq.delete();
        apb(1'b1, `CCPP_A_CTRL, 32'h00001000);
        apb(1'b1, `CCPP_A_CTRL, 32'h0);
        repeat (160) @(posedge mclk);
        check(outq.size(), `CCPP_SCALES * `CCPP_STEPS, "pat n");
        for (int k = 0; k < outq.size(); k++) begin
            check(leq[k], k % `CCPP_STEPS == `CCPP_STEPS - 1,
                  "pat end");
            check(outq[k].tag == CCPP_PHOTO, k >= 4 * `CCPP_STEPS,
                  "pat mode");
            if (k % `CCPP_STEPS == 0)
                check({outq[k].y, outq[k].m, outq[k].c, outq[k].k}, 0,
                      "pat white");
        end
        tally_and_finish();
    end
endmodule
